// ===== src/qdl_pkg.sv
// Shared constants for the quad converter load decoder.
package qdl_pkg;
  // ----------------------------------------
  // Serial frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int LD_HI_POS = 15;
  localparam int LD_LO_POS = 14;
  localparam int SEL_HI_POS = 13;
  localparam int SEL_LO_POS = 12;
  localparam int CODE_W = 12;
  localparam int PD_ALL_POS = 11;
  localparam int PD_CH_HI_POS = 10;
  localparam int PD_CH_LO_POS = 9;
  localparam int PD_MODE_HI_POS = 8;
  localparam int PD_MODE_LO_POS = 7;
  localparam int NUM_CH = 4;
  localparam logic [1:0] LD_STORE = 2'h0;
  localparam logic [1:0] LD_XFER = 2'h1;
  localparam logic [1:0] LD_BOTH = 2'h2;
  localparam logic [1:0] LD_BCAST = 2'h3;
  localparam logic [1:0] BC_STORE = 2'h0;
  localparam logic [1:0] BC_XFER = 2'h1;
  localparam logic [1:0] BC_BOTH = 2'h2;
  localparam logic [1:0] BC_PWD = 2'h3;
  localparam logic [CODE_W-1:0] ZERO_SCALE = 12'h000;
  // ----------------------------------------
  // Output stage state driven to the analog side
  // ----------------------------------------
  typedef enum logic [1:0] {
    QDL_OUT_ACTIVE = 2'h0,
    QDL_OUT_1K = 2'h1,
    QDL_OUT_100K = 2'h2,
    QDL_OUT_HIZ = 2'h3
  } qdl_out_type;
  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DAC_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IN_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_FRAMES = 8'h28;
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_CLR_POS = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int FRAME_CNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : qdl_pkg

// ===== src/qdl_top.sv
// Serial command decoder and register file of the quad converter load block.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Commands arrive only on the write-only three-wire serial link.
// - Load code 00 stores data in the selected channel's input register.
// - Load code 01 copies the selected input register into its converter register.
// - Load code 10 loads data into both input and converter registers.
// - Load code 11 with select 11 makes the data a power-down command.
// - Converter register changes reach the output at once; input stores do not.
// - A falling frame sync starts a new frame.
// - Reset clears the channel registers, sets the control enable, and drives zero scale on all channels.
// - Power-down data bit 11 picks all channels, else bits 10:9; bits 8:7 the impedance.
module qdl_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [qdl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [qdl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_sclk,
  input wire logic frame_sync_n,
  input wire logic link_din,
  output logic [qdl_pkg::CODE_W-1:0] dac_code_a,
  output logic [qdl_pkg::CODE_W-1:0] dac_code_b,
  output logic [qdl_pkg::CODE_W-1:0] dac_code_c,
  output logic [qdl_pkg::CODE_W-1:0] dac_code_d,
  output qdl_pkg::qdl_out_type out_state_a,
  output qdl_pkg::qdl_out_type out_state_b,
  output qdl_pkg::qdl_out_type out_state_c,
  output qdl_pkg::qdl_out_type out_state_d
);
  import qdl_pkg::*;

  // ----------------------------------------
  // Link reset taken from the bus domain
  // ----------------------------------------
  logic link_rst_n_r;
  logic cnt_clr;
  always_ff @(posedge aclk) begin
    link_rst_n_r <= aresetn;
  end
  // The bit counter is cleared while frame sync is high, so the next falling
  // frame sync always starts counting at bit zero.
  assign cnt_clr = frame_sync_n | ~link_rst_n_r;

  // ----------------------------------------
  // Link domain: shift register on falling serial clock
  // ----------------------------------------
  logic [CNT_W-1:0] bit_cnt_r;
  logic [FRAME_BITS-2:0] shift_r;
  logic [FRAME_BITS-1:0] word_r;
  logic word_tgl_r;
  always_ff @(negedge link_sclk or posedge cnt_clr) begin
    if (cnt_clr) begin
      bit_cnt_r <= '0;
    end else if (bit_cnt_r < CNT_W'(FRAME_BITS)) begin
      bit_cnt_r <= bit_cnt_r + CNT_W'(1);
    end
  end
  always_ff @(negedge link_sclk) begin
    if (!frame_sync_n && bit_cnt_r < CNT_W'(FRAME_BITS - 1)) begin
      shift_r <= {shift_r[FRAME_BITS-3:0], link_din};
    end
  end
  always_ff @(negedge link_sclk or negedge link_rst_n_r) begin
    if (!link_rst_n_r) begin
      word_r <= '0;
      word_tgl_r <= 1'b0;
    end else if (!frame_sync_n && bit_cnt_r == CNT_W'(FRAME_BITS - 1)) begin
      word_r <= {shift_r, link_din};
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // ----------------------------------------
  // Crossing of the frame event into the bus domain
  // ----------------------------------------
  logic tgl_meta_r;
  logic tgl_sync_r;
  logic tgl_seen_r;
  logic frame_evt;
  logic ctrl_en_r;
  logic clr_pulse_r;
  logic cmd_go_r;
  logic [FRAME_BITS-1:0] cmd_r;
  logic [FRAME_CNT_W-1:0] frame_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= word_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end
  assign frame_evt = tgl_sync_r ^ tgl_seen_r;
  // The frame word stays stable for a whole frame after its toggle, so it can
  // be sampled here once the toggle has passed the synchroniser.
  // serial commands only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_go_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      cmd_go_r <= frame_evt & ctrl_en_r;
      if (frame_evt) begin
        cmd_r <= word_r;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt_r <= '0;
    end else if (frame_evt) begin
      frame_cnt_r <= frame_cnt_r + FRAME_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic [1:0] ld_code;
  logic [1:0] sel_code;
  logic [CODE_W-1:0] data_code;
  logic [1:0] pd_ch;
  logic pd_all;
  qdl_out_type pd_state;
  assign ld_code = {cmd_r[LD_HI_POS], cmd_r[LD_LO_POS]};
  assign sel_code = {cmd_r[SEL_HI_POS], cmd_r[SEL_LO_POS]};
  assign data_code = cmd_r[CODE_W-1:0];
  assign pd_all = cmd_r[PD_ALL_POS];
  assign pd_ch = {cmd_r[PD_CH_HI_POS], cmd_r[PD_CH_LO_POS]};
  always_comb begin
    case ({cmd_r[PD_MODE_HI_POS], cmd_r[PD_MODE_LO_POS]})
      2'h1: pd_state = QDL_OUT_1K;
      2'h2: pd_state = QDL_OUT_100K;
      default: pd_state = QDL_OUT_HIZ;
    endcase
  end

  // ----------------------------------------
  // Per channel input and converter registers
  // ----------------------------------------
  logic [CODE_W-1:0] in_r [NUM_CH];
  logic [CODE_W-1:0] dac_r [NUM_CH];
  qdl_out_type state_r [NUM_CH];
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic hit;
    logic wr_in;
    logic xfer;
    logic wr_dac;
    logic pd_hit;
    assign hit = (sel_code == 2'(ch));
    assign wr_in = cmd_go_r & (((ld_code == LD_STORE || ld_code == LD_BOTH) & hit) |
                   (ld_code == LD_BCAST & (sel_code == BC_STORE || sel_code == BC_BOTH)));
    assign xfer = cmd_go_r & ((ld_code == LD_XFER & hit) |
                  (ld_code == LD_BCAST & sel_code == BC_XFER));
    assign wr_dac = cmd_go_r & ((ld_code == LD_BOTH & hit) |
                    (ld_code == LD_BCAST & sel_code == BC_BOTH));
    assign pd_hit = cmd_go_r & ld_code == LD_BCAST & sel_code == BC_PWD &
                    (pd_all | pd_ch == 2'(ch));
    always_ff @(posedge aclk) begin
      if (!aresetn || clr_pulse_r) begin
        in_r[ch] <= ZERO_SCALE;
      end else if (wr_in) begin
        in_r[ch] <= data_code;
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn || clr_pulse_r) begin
        dac_r[ch] <= ZERO_SCALE;
      end else if (wr_dac) begin
        dac_r[ch] <= data_code;
      end else if (xfer) begin
        dac_r[ch] <= in_r[ch];
      end
    end
    // A converter update wakes a channel from power-down.
    // per channel power-down
    always_ff @(posedge aclk) begin
      if (!aresetn || clr_pulse_r) begin
        state_r[ch] <= QDL_OUT_ACTIVE;
      end else if (pd_hit) begin
        state_r[ch] <= pd_state;
      end else if (wr_dac || xfer) begin
        state_r[ch] <= QDL_OUT_ACTIVE;
      end
    end
  end
  assign dac_code_a = dac_r[0];
  assign dac_code_b = dac_r[1];
  assign dac_code_c = dac_r[2];
  assign dac_code_d = dac_r[3];
  assign out_state_a = state_r[0];
  assign out_state_b = state_r[1];
  assign out_state_c = state_r[2];
  assign out_state_d = state_r[3];

  // ----------------------------------------
  // Bus write channel
  // ----------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic do_write;
  logic wr_mapped;
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_mapped = aw_addr_r[ADDR_W-1:2] <= OFS_FRAMES[ADDR_W-1:2];
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  // Only the control word is writable; other mapped writes are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_r <= CTRL_EN_RST;
      clr_pulse_r <= 1'b0;
    end else begin
      clr_pulse_r <= 1'b0;
      if (do_write && aw_addr_r[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2] && w_strb_r[0]) begin
        ctrl_en_r <= w_data_r[CTRL_EN_POS];
        clr_pulse_r <= w_data_r[CTRL_CLR_POS];
      end
    end
  end

  // ----------------------------------------
  // Bus read channel
  // ----------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic [ADDR_W-3:0] rd_idx;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (rd_idx < OFS_IN_BASE[ADDR_W-1:2]) begin
      rd_val[CODE_W-1:0] = dac_r[rd_idx[1:0]];
    end else if (rd_idx < OFS_STATUS[ADDR_W-1:2]) begin
      rd_val[CODE_W-1:0] = in_r[rd_idx[1:0]];
    end else if (rd_idx == OFS_STATUS[ADDR_W-1:2]) begin
      rd_val[7:0] = {state_r[3], state_r[2], state_r[1], state_r[0]};
    end else if (rd_idx == OFS_CTRL[ADDR_W-1:2]) begin
      rd_val[CTRL_EN_POS] = ctrl_en_r;
    end else if (rd_idx == OFS_FRAMES[ADDR_W-1:2]) begin
      rd_val[FRAME_CNT_W-1:0] = frame_cnt_r;
    end else begin
      rd_resp = RESP_DECERR;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule : qdl_top
`default_nettype wire

// ===== verif/qdl_properties.sv
// Concurrent checks on the ports of the load decoder top.
`timescale 1ns/10ps
`default_nettype none
module qdl_properties
  import qdl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [qdl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_sync_n,
  input wire logic [qdl_pkg::CODE_W-1:0] dac_code_a,
  input wire logic [qdl_pkg::CODE_W-1:0] dac_code_b,
  input wire logic [qdl_pkg::CODE_W-1:0] dac_code_c,
  input wire logic [qdl_pkg::CODE_W-1:0] dac_code_d,
  input wire qdl_pkg::qdl_out_type out_state_a
);
  logic [4:0] idle_r;
  // Counts bus clocks since the frame sync was last low or a write was taken,
  // since a control write may clear the channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn || !frame_sync_n || (s_axi_wvalid && s_axi_wready)) begin
      idle_r <= 5'h00;
    end else if (idle_r != 5'h1F) begin
      idle_r <= idle_r + 5'h01;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_zero_a: assert property (disable iff (1'b0)
    !aresetn |=> dac_code_a == 12'h000 && out_state_a == QDL_OUT_ACTIVE)
    else $error("output not cleared by reset");
  idle_hold_a: assert property (idle_r == 5'h1F |->
    $stable({dac_code_a, dac_code_b, dac_code_c, dac_code_d}) && $stable(out_state_a))
    else $error("output moved with no frame");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h0A
    |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
  cover property (out_state_a == QDL_OUT_1K);
endmodule : qdl_properties
`default_nettype wire

// ===== verif/qdl_host_model.sv
// Serial host that writes frames into the decoder link.
`timescale 1ns/10ps
`default_nettype none
module qdl_host_model (
  output logic link_sclk,
  output logic frame_sync_n,
  output logic link_din
);
  initial begin
    link_sclk = 1'b1;
    frame_sync_n = 1'b1;
    link_din = 1'b0;
  end
  // sync falls, bits go out first bit highest, taken on falling clock.
  task automatic send(input logic [15:0] w, input int nbits);
    #1.3;
    frame_sync_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      link_din = w[i];
      #62.5 link_sclk = 1'b0;
      #62.5 link_sclk = 1'b1;
    end
    frame_sync_n = 1'b1;
    link_din = ~link_din;
    #100;
  endtask : send
endmodule : qdl_host_model
`default_nettype wire

// ===== verif/quad_dac_load_decoder_bench.sv
// Self-checking bench for the quad converter load decoder.
`timescale 1ns/10ps
`default_nettype none
module quad_dac_load_decoder_bench;
  import qdl_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, sclk, fs_n, din;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv, fc;
  logic [1:0] bresp, rresp, rs;
  logic [11:0] code [4];
  logic [11:0] in_m [4];
  logic [11:0] dac_m [4];
  qdl_out_type st [4];
  qdl_out_type st_m [4];
  int n_fail = 0;
  int checked = 0;
  always #2 aclk = ~aclk;
  qdl_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_sclk(sclk), .frame_sync_n(fs_n), .link_din(din), .dac_code_a(code[0]),
    .dac_code_b(code[1]), .dac_code_c(code[2]), .dac_code_d(code[3]), .out_state_a(st[0]),
    .out_state_b(st[1]), .out_state_c(st[2]), .out_state_d(st[3]));
  qdl_host_model host (.link_sclk(sclk), .frame_sync_n(fs_n), .link_din(din));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    chk(n, 3);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    chk(n, 2);
  endtask : axr
  // Expected channel state after one accepted frame.
  function automatic void apply(input logic [15:0] w);
    logic [1:0] op;
    op = (w[15:14] == LD_BCAST) ? w[13:12] : w[15:14];
    for (int c = 0; c < 4; c++) begin
      if (w[15:12] == 4'hF) begin
        if (w[11] || w[10:9] == c[1:0]) st_m[c] = (w[8:7] == 2'h1) ? QDL_OUT_1K :
          (w[8:7] == 2'h2) ? QDL_OUT_100K : QDL_OUT_HIZ;
      end else if (w[15:14] == LD_BCAST || w[13:12] == c[1:0]) begin
        if (op != 2'h1) in_m[c] = w[11:0];
        if (op != 2'h0) begin
          dac_m[c] = in_m[c];
          st_m[c] = QDL_OUT_ACTIVE;
        end
      end
    end
  endfunction : apply
  task cmp_all;
    repeat (8) @(posedge aclk);
    for (int c = 0; c < 4; c++) begin
      chk(code[c], dac_m[c]);
      chk(st[c], st_m[c]);
    end
  endtask : cmp_all
  task frame(input logic [15:0] w);
    host.send(w, 16);
    apply(w);
    cmp_all();
  endtask : frame
  initial begin
    #300000;
    n_fail++;
    give_verdict();
  end
  initial begin
    for (int c = 0; c < 4; c++) begin
      in_m[c] = 12'h000;
      dac_m[c] = 12'h000;
      st_m[c] = QDL_OUT_ACTIVE;
    end
    void'($urandom(32'h8A2F0A4F));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cmp_all();
    axr(OFS_CTRL, rv, rs);
    chk(rv, 32'h1);
    for (int i = 0; i < 16; i++) frame({i[3:0], 12'($urandom)});
    for (int i = 0; i < 16; i++) frame({5'h1E, i[3:0], 7'($urandom)});
    for (int i = 0; i < 4; i++) frame({5'h1F, 2'($urandom), i[1:0], 7'($urandom)});
    for (int i = 0; i < 20; i++) frame(16'($urandom));
    host.send(16'h9ABC, 10);
    cmp_all();
    axr(OFS_FRAMES, fc, rs);
    axw(OFS_CTRL, 32'h0, rs);
    host.send(16'h9ABC, 16);
    cmp_all();
    axr(OFS_FRAMES, rv, rs);
    chk(rv, fc + 32'h1);
    axw(OFS_CTRL, 32'h1, rs);
    for (int c = 0; c < 4; c++) begin
      axr(OFS_DAC_BASE + 8'(4 * c), rv, rs);
      chk(rv, dac_m[c]);
      axr(OFS_IN_BASE + 8'(4 * c), rv, rs);
      chk(rv, in_m[c]);
    end
    axr(OFS_STATUS, rv, rs);
    chk(rv, {st_m[3], st_m[2], st_m[1], st_m[0]});
    axr(8'h30, rv, rs);
    chk(rs, RESP_DECERR);
    axw(8'h30, 32'h5, rs);
    chk(rs, RESP_DECERR);
    axw(OFS_DAC_BASE, 32'hFFF, rs);
    chk(rs, RESP_OKAY);
    cmp_all();
    axw(OFS_CTRL, 32'h3, rs);
    for (int c = 0; c < 4; c++) begin
      in_m[c] = ZERO_SCALE;
      dac_m[c] = ZERO_SCALE;
      st_m[c] = QDL_OUT_ACTIVE;
    end
    cmp_all();
    axr(OFS_IN_BASE + 8'h04, rv, rs);
    chk(rv, 32'h0);
    axr(OFS_CTRL, rv, rs);
    chk(rv, 32'h1);
    give_verdict();
  end
endmodule : quad_dac_load_decoder_bench
bind qdl_top qdl_properties props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .frame_sync_n, .dac_code_a, .dac_code_b, .dac_code_c, .dac_code_d, .out_state_a);
`default_nettype wire
